// ### rtl/pftc_cfg.svh
// Offsets, field positions, reset values and timing counts of the span and rate block.
`ifndef PFTC_CFG_SVH
`define PFTC_CFG_SVH

`define PFTC_ADDR_W          8
`define PFTC_OFF_CH0         8'h5f
`define PFTC_OFF_CH1         8'h60
`define PFTC_OFF_CH2         8'h61
`define PFTC_OFF_LOCK        8'h40
`define PFTC_OFF_IRQ_STAT    8'h70
`define PFTC_OFF_IRQ_MASK    8'h71
`define PFTC_OFF_PIN_STAT    8'h72
`define PFTC_CH_RESET        8'hc4
`define PFTC_LOCK_BIT        0
`define PFTC_RATE_LSB        0
`define PFTC_ALARM_BIT       3
`define PFTC_SPAN_LSB        4
`define PFTC_CLK_HZ          50000000
`define PFTC_MON_CYCLE_MS    100
`define PFTC_MON_CYCLES      ((`PFTC_CLK_HZ / 1000) * `PFTC_MON_CYCLE_MS)
`define PFTC_NUM_CH          3
`define PFTC_PRESC_W         24
`define PFTC_PERIOD_W        24
`define PFTC_RATE_P0         24'h455bae
`define PFTC_RATE_P1         24'h33e690
`define PFTC_RATE_P2         24'h2285ab
`define PFTC_RATE_P3         24'h19f348
`define PFTC_RATE_P4         24'h159cee
`define PFTC_RATE_P5         24'h114cda
`define PFTC_RATE_P6         24'h0cf9a4
`define PFTC_RATE_P7         24'h08a66d

`endif

// ### rtl/pftc_pkg.sv
// Types shared by the span and rate block.
package pftc_pkg;
    typedef struct packed {
        logic [3:0] control_span;
        logic       overtemp_output_enable;
        logic [2:0] drive_rate_select;
    } pftc_chan_cfg_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pftc_bus_req_t;

    typedef enum logic [1:0] {
        PFTC_ALM_IDLE = 2'b00,
        PFTC_ALM_HOLD = 2'b01,
        PFTC_ALM_WAIT = 2'b10
    } pftc_alm_state_t;
endpackage

// ### rtl/pftc_rate_gen.sv
// Drive rate period generator for one channel.
`timescale 1ns/1ps
`default_nettype none
`include "pftc_cfg.svh"
module pftc_rate_gen
    import pftc_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [2:0] rate_sel_i,
    output logic            rate_tick_o
);
    logic [`PFTC_PERIOD_W-1:0] period;
    logic [`PFTC_PERIOD_W-1:0] cnt_reg;
    logic [`PFTC_PERIOD_W-1:0] cnt_next;
    logic                      tick_reg;

    // rate period table.
    // Periods are clocks at 50 MHz for 11.0 .. 88.2 Hz.
    always_comb begin
        case (rate_sel_i)
            3'h0: period = `PFTC_RATE_P0;
            3'h1: period = `PFTC_RATE_P1;
            3'h2: period = `PFTC_RATE_P2;
            3'h3: period = `PFTC_RATE_P3;
            3'h4: period = `PFTC_RATE_P4;
            3'h5: period = `PFTC_RATE_P5;
            3'h6: period = `PFTC_RATE_P6;
            default: period = `PFTC_RATE_P7;
        endcase
    end

    assign cnt_next = (cnt_reg >= period - 24'h1) ? '0 : cnt_reg + 24'h1;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= (cnt_next == '0);
        end
    end

    assign rate_tick_o = tick_reg;
endmodule // pftc_rate_gen
`default_nettype wire

// ### rtl/pftc_alarm.sv
// Over-temperature alarm hold logic for one channel.
`timescale 1ns/1ps
`default_nettype none
`include "pftc_cfg.svh"
module pftc_alarm
    import pftc_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic enable_i,
    input  wire logic over_limit_i,
    input  wire logic mon_tick_i,
    output logic      assert_o
);
    pftc_alm_state_t state_reg;
    pftc_alm_state_t state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PFTC_ALM_IDLE: begin
                if (enable_i && over_limit_i)
                    state_next = PFTC_ALM_HOLD;
            end
            PFTC_ALM_HOLD: begin
                if (!enable_i)
                    state_next = PFTC_ALM_IDLE;
                else if (mon_tick_i)
                    state_next = PFTC_ALM_WAIT;
            end
            PFTC_ALM_WAIT: begin
                if (!enable_i || !over_limit_i)
                    state_next = PFTC_ALM_IDLE;
            end
            default: state_next = PFTC_ALM_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            state_reg <= PFTC_ALM_IDLE;
        else
            state_reg <= state_next;
    end

    // A cleared enable drops the hold, so a later enable cannot revive it.
    assign assert_o = (state_reg != PFTC_ALM_IDLE);
endmodule // pftc_alarm
`default_nettype wire

// ### rtl/pftc_top.sv
// Span and drive rate registers with over-temperature pin control.
//
// Functional notes
// - Once the lock bit is set, writes to the three channel registers are ignored.
// - Bits 2 to 0 select the drive rate from 11.0 Hz up to 88.2 Hz.
// - With bit 3 set the pin is driven low while the channel exceeds its limit.
// - A driven pin stays low until the temperature is at or below the limit.
// - Each assertion lasts at least until the end of the current monitoring cycle; the code ends it at once when bit 3 is cleared.
// - With bit 3 clear the pin is never driven and serves as an input only.
// - Bits 7 to 4 give the control span from 2 to 80 degrees.
`timescale 1ns/1ps
`default_nettype none
`include "pftc_cfg.svh"
module pftc_top
    import pftc_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic [7:0]      rdata_o,
    input  wire logic [2:0] over_limit_i,
    input  wire logic       overtemp_pin_i,
    output logic            overtemp_pin_o,
    output logic            overtemp_pin_oe_o,
    output logic [2:0]      rate_tick_o,
    output logic [11:0]     control_span_o,
    output logic            irq_o
);
    ////////////////////////////////////////////////////////////////////////
    pftc_bus_req_t  req;
    pftc_chan_cfg_t cfg_reg [`PFTC_NUM_CH];
    logic [7:0]     rdata_reg;
    logic           lock_reg;
    logic [2:0]     irq_stat_reg;
    logic [2:0]     irq_mask_reg;
    logic [23:0]    mon_cnt_reg;
    logic           mon_tick;
    logic [2:0]     alm_assert;
    logic [2:0]     alm_prev_reg;
    logic           pin_s1_reg;
    logic           pin_s2_reg;
    logic           pin_prev_reg;
    logic           hot_event;
    logic [2:0]     ch_sel;
    logic [2:0]     drive_en;
    logic           stat_wr;
    logic           mask_wr;
    logic           lock_wr;
    logic [2:0]     irq_set;
    logic [7:0]     rd_mux;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    assign ch_sel[0] = (req.addr == `PFTC_OFF_CH0);
    assign ch_sel[1] = (req.addr == `PFTC_OFF_CH1);
    assign ch_sel[2] = (req.addr == `PFTC_OFF_CH2);
    assign lock_wr   = req.wr && (req.addr == `PFTC_OFF_LOCK);
    assign stat_wr   = req.wr && (req.addr == `PFTC_OFF_IRQ_STAT);
    assign mask_wr   = req.wr && (req.addr == `PFTC_OFF_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////
    // Lock is sticky until reset, so software cannot reopen the tables.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            lock_reg <= 1'b0;
        else if (lock_wr && req.wdata[`PFTC_LOCK_BIT])
            lock_reg <= 1'b1;
    end

    genvar g;
    generate
        for (g = 0; g < `PFTC_NUM_CH; g++) begin : g_ch
            always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i)
                    cfg_reg[g] <= pftc_chan_cfg_t'(`PFTC_CH_RESET);
                else if (req.wr && ch_sel[g] && !lock_reg)
                    cfg_reg[g] <= pftc_chan_cfg_t'(req.wdata);
            end

            pftc_rate_gen u_rate (
                .ref_clk_i   (ref_clk_i),
                .sys_rst_i   (sys_rst_i),
                .rate_sel_i  (cfg_reg[g].drive_rate_select),
                .rate_tick_o (rate_tick_o[g])
            );

            pftc_alarm u_alarm (
                .ref_clk_i    (ref_clk_i),
                .sys_rst_i    (sys_rst_i),
                .enable_i     (cfg_reg[g].overtemp_output_enable),
                .over_limit_i (over_limit_i[g]),
                .mon_tick_i   (mon_tick),
                .assert_o     (alm_assert[g])
            );

            assign drive_en[g] = alm_assert[g] &&
                                 cfg_reg[g].overtemp_output_enable;
            assign control_span_o[g*4 +: 4] = cfg_reg[g].control_span;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Monitoring cycle timer shared by all channels.
    assign mon_tick = (mon_cnt_reg == 24'(`PFTC_MON_CYCLES - 1));

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            mon_cnt_reg <= '0;
        else if (mon_tick)
            mon_cnt_reg <= '0;
        else
            mon_cnt_reg <= mon_cnt_reg + 24'h1;
    end

    assign overtemp_pin_o    = 1'b0;
    assign overtemp_pin_oe_o = |drive_en;

    ////////////////////////////////////////////////////////////////////////
    // External hot indication is sampled twice before use.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_s1_reg   <= 1'b1;
            pin_s2_reg   <= 1'b1;
            pin_prev_reg <= 1'b1;
            alm_prev_reg <= '0;
        end else begin
            pin_s1_reg   <= overtemp_pin_i;
            pin_s2_reg   <= pin_s1_reg;
            pin_prev_reg <= pin_s2_reg;
            alm_prev_reg <= drive_en;
        end
    end

    // Our own drive also pulls the pin, so only foreign lows count.
    assign hot_event = pin_prev_reg && !pin_s2_reg && !(|drive_en);
    assign irq_set   = {hot_event, |(drive_en & ~alm_prev_reg),
                        |(~drive_en & alm_prev_reg)};

    // Set wins over a write-one clear in the same cycle.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~(stat_wr ? req.wdata[2:0]
                                                      : 3'h0)) | irq_set;
            if (mask_wr)
                irq_mask_reg <= req.wdata[2:0];
        end
    end

    assign irq_o = |(irq_stat_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        case (req.addr)
            `PFTC_OFF_CH0:      rd_mux = cfg_reg[0];
            `PFTC_OFF_CH1:      rd_mux = cfg_reg[1];
            `PFTC_OFF_CH2:      rd_mux = cfg_reg[2];
            `PFTC_OFF_LOCK:     rd_mux = {7'h00, lock_reg};
            `PFTC_OFF_IRQ_STAT: rd_mux = {5'h00, irq_stat_reg};
            `PFTC_OFF_IRQ_MASK: rd_mux = {5'h00, irq_mask_reg};
            `PFTC_OFF_PIN_STAT: rd_mux = {4'h0, pin_s2_reg, alm_assert};
            default:            rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            rdata_reg <= '0;
        else if (req.rd)
            rdata_reg <= rd_mux;
        else
            rdata_reg <= '0;
    end

    assign rdata_o = rdata_reg;
endmodule // pftc_top
`default_nettype wire

// ### tb/pftc_far_model.sv
// Open-drain pin with pull-up and the external pull-down source.
`timescale 1ns/1ps
`default_nettype none
module pftc_far_model (
    input  wire logic oe_i,
    input  wire logic ext_low_i,
    output logic      pin_o
);
    assign pin_o = ~(oe_i | ext_low_i);
endmodule // pftc_far_model
`default_nettype wire

// ### tb/pftc_top_props.sv
// Port checker of the span and rate block.
`timescale 1ns/1ps
`default_nettype none
module pftc_top_props (
    input wire logic        ref_clk_i,
    input wire logic        sys_rst_i,
    input wire logic [7:0]  addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic [2:0]  over_limit_i,
    input wire logic        overtemp_pin_o,
    input wire logic        overtemp_pin_oe_o,
    input wire logic [2:0]  rate_tick_o,
    input wire logic [11:0] control_span_o,
    input wire logic        irq_o
);
    logic lock_q;
    // Shadow of the lock, sticky like the real one.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            lock_q <= 1'b0;
        else if (wr_i && addr_i == 8'h40 && wdata_i[0])
            lock_q <= 1'b1;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_ch0_wr;
        wr_i && addr_i == 8'h5f;
    endsequence
    property p_lock;
        lock_q ##0 s_ch0_wr |=> $stable(control_span_o) [*2];
    endproperty
    a_lock: assert property (p_lock) else $error("locked write took");
    property p_span_wr;
        !lock_q && wr_i && addr_i == 8'h60
            |=> control_span_o[7:4] == $past(wdata_i[7:4]);
    endproperty
    a_span_wr: assert property (p_span_wr) else $error("span lost");
    property p_rd_span;
        rd_i && addr_i == 8'h61 && !$past(wr_i)
            |=> rdata_o[7:4] == control_span_o[11:8];
    endproperty
    a_rd_span: assert property (p_rd_span) else $error("bad map");
    property p_rd_idle;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray rdata");
    property p_pin_o;
        overtemp_pin_o == 1'b0;
    endproperty
    a_pin_o: assert property (p_pin_o) else $error("pin driven high");
    property p_oe_cause;
        $rose(overtemp_pin_oe_o) |-> $past(|over_limit_i);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("bad alarm");
    property p_oe_keep;
        overtemp_pin_oe_o && (&over_limit_i) && !wr_i |=> overtemp_pin_oe_o;
    endproperty
    a_oe_keep: assert property (p_oe_keep) else $error("alarm let go");
    property p_span_rst;
        $fell(sys_rst_i) |-> control_span_o == 12'hccc;
    endproperty
    a_span_rst: assert property (p_span_rst) else $error("span reset");
    property p_idle_rst;
        $fell(sys_rst_i) |-> !overtemp_pin_oe_o && !irq_o;
    endproperty
    a_idle_rst: assert property (p_idle_rst) else $error("pin reset");
endmodule // pftc_top_props
bind pftc_top pftc_top_props pftc_top_props_inst (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .over_limit_i(over_limit_i), .overtemp_pin_o(overtemp_pin_o),
    .overtemp_pin_oe_o(overtemp_pin_oe_o), .rate_tick_o(rate_tick_o),
    .control_span_o(control_span_o), .irq_o(irq_o));
`default_nettype wire

// ### tb/tb_top.sv
// Register and pin bench of the span and rate block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [2:0]  over_limit = 3'b000;
    logic        ext_low = 1'b0;
    logic [7:0]  rdata;
    logic        pin_drv;
    logic        oe;
    logic        pin_lvl;
    logic [2:0]  ticks;
    logic [11:0] spans;
    logic        irq;
    int          num_errors = 0;
    int          cmp_count = 0;
    always #10 ref_clk = ~ref_clk;
    pftc_top pftc_top_inst (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .over_limit_i(over_limit),
        .overtemp_pin_i(pin_lvl), .overtemp_pin_o(pin_drv),
        .overtemp_pin_oe_o(oe), .rate_tick_o(ticks),
        .control_span_o(spans), .irq_o(irq));
    pftc_far_model pftc_far_model_inst (.oe_i(oe), .ext_low_i(ext_low),
        .pin_o(pin_lvl));
    ////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [11:0] ex, input logic [11:0] got);
        cmp_count++;
        if (got !== ex) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe.
    task rdchk(input string nm, input logic [7:0] a, input logic [7:0] ex,
               input logic [7:0] m);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk(nm, ex, rdata & m);
    endtask
    task settle;
        @(posedge ref_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 3; i++)
            rdchk("chan", 8'h5f + 8'(i), 8'hc4, 8'hff);
        wr8(8'h5f, 8'h07);
        wr8(8'h60, 8'hf0);
        wr8(8'h61, 8'h51);
        rdchk("ch0", 8'h5f, 8'h07, 8'hff);
        rdchk("ch1", 8'h60, 8'hf0, 8'hff);
        rdchk("ch2", 8'h61, 8'h51, 8'hff);
        chk("spans", 12'h5f0, spans);
        @(posedge ref_clk);
        over_limit <= 3'b111;
        repeat (6) settle();
        chk("oe off", 12'h000, oe);
        wr8(8'h60, 8'hf8);
        // Bounded wait; a late alarm ends the run.
        for (int n = 0; n < 8 && oe !== 1'b1; n++)
            settle();
        chk("oe on", 12'h001, oe);
        if (oe !== 1'b1)
            stop_test();
        chk("pin low", 12'h000, pin_lvl);
        @(posedge ref_clk);
        over_limit <= 3'b000;
        repeat (20) settle();
        chk("oe hold", 12'h001, oe);
        rdchk("stat", 8'h70, 8'h02, 8'h02);
        chk("irq masked", 12'h000, irq);
        wr8(8'h71, 8'h02);
        settle();
        chk("irq on", 12'h001, irq);
        wr8(8'h70, 8'h02);
        settle();
        chk("irq clr", 12'h000, irq);
        wr8(8'h60, 8'hf0);
        chk("oe drop", 12'h000, oe);
        // Let the released pin reach the synchroniser high first.
        repeat (4) settle();
        @(posedge ref_clk);
        ext_low <= 1'b1;
        repeat (4) settle();
        chk("input only", 12'h000, oe);
        rdchk("ext fall", 8'h70, 8'h04, 8'h04);
        rdchk("stat end", 8'h70, 8'h01, 8'h01);
        wr8(8'h40, 8'h01);
        wr8(8'h5f, 8'h33);
        rdchk("locked", 8'h5f, 8'h07, 8'hff);
        rdchk("unmapped", 8'h7f, 8'h00, 8'hff);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
